// ==== pkg/tsd_pkg.sv ====
// terminal status display: shared constants, field layouts, types and the hex font
package tsd_pkg;

  // apb register map (byte addresses)
  localparam int unsigned        TSD_ADDR_W        = 8;
  localparam logic [7:0]         TSD_OFF_CTRL      = 8'h00;
  localparam logic [7:0]         TSD_OFF_IN_WORD   = 8'h04;
  localparam logic [7:0]         TSD_OFF_OUT_WORD  = 8'h08;
  localparam logic [7:0]         TSD_OFF_SEG       = 8'h0c;
  localparam logic [7:0]         TSD_OFF_TERM_RAW  = 8'h10;
  localparam logic [7:0]         TSD_OFF_OPT_RAW   = 8'h14;
  localparam logic [1:0]         TSD_ALIGN_OK      = 2'h0;

  // control register fields
  localparam int unsigned        TSD_CTRL_HEX_BIT  = 0;
  localparam int unsigned        TSD_CTRL_SRC_LSB  = 1;
  localparam int unsigned        TSD_CTRL_WSEL_BIT = 3;
  localparam logic [31:0]        TSD_CTRL_MASK     = 32'h0000000f;
  localparam logic [31:0]        TSD_CTRL_RESET    = 32'h00000000;

  // view source codes in the control register
  localparam logic [1:0]         TSD_SRC_TERM      = 2'h0;
  localparam logic [1:0]         TSD_SRC_COMM      = 2'h1;
  localparam logic [1:0]         TSD_SRC_OPT       = 2'h2;

  // status word bit positions
  localparam int unsigned        TSD_BIT_FWD       = 0;
  localparam int unsigned        TSD_BIT_REV       = 1;
  localparam int unsigned        TSD_BIT_GEN_LSB   = 2;
  localparam int unsigned        TSD_BIT_TR_LSB    = 0;
  localparam int unsigned        TSD_BIT_RELAY     = 8;
  localparam int unsigned        TSD_BIT_CFWD      = 13;
  localparam int unsigned        TSD_BIT_CREV      = 14;
  localparam int unsigned        TSD_BIT_CRST      = 15;
  localparam int unsigned        TSD_BIT_OPT_SEL   = 12;
  localparam int unsigned        TSD_BIT_OPT_OLSB  = 0;

  // widths
  localparam int unsigned        TSD_GEN_N         = 5;
  localparam int unsigned        TSD_TR_N          = 2;
  localparam int unsigned        TSD_OPT_IN_N      = 12;
  localparam int unsigned        TSD_OPT_OUT_N     = 8;
  localparam int unsigned        TSD_DIGITS        = 4;
  localparam logic [15:0]        TSD_WORD_ZERO     = 16'h0000;

  // segment bit positions within one digit, a at bit 0 up to dp at bit 7
  localparam int unsigned        TSD_SEG_A         = 0;
  localparam int unsigned        TSD_SEG_B         = 1;
  localparam int unsigned        TSD_SEG_F         = 5;
  localparam int unsigned        TSD_SEG_G         = 6;
  localparam int unsigned        TSD_SEG_DP        = 7;
  localparam logic [7:0]         TSD_SEG_DASH      = 8'h40;
  localparam logic [7:0]         TSD_SEG_BLANK     = 8'h00;

  typedef logic [15:0] tsd_word_t;
  typedef logic [7:0]  tsd_digit_t;

  // physical control terminals, one means circuit closed
  typedef struct packed {
    logic                        relay_contact_output;
    logic [TSD_TR_N-1:0]         transistor_output;
    logic [TSD_GEN_N-1:0]        general_input;
    logic                        reverse_run_input;
    logic                        forward_run_input;
  } tsd_term_s;

  // commands from the communications link, normal logic
  typedef struct packed {
    logic                        comm_alarm_reset_command;
    logic                        comm_reverse_command;
    logic                        comm_forward_command;
    logic [15:0]                 comm_input_command_word;
  } tsd_comm_s;

  // optional digital i/o board
  typedef struct packed {
    logic                        option_select_input;
    logic [TSD_OPT_IN_N-1:0]     option_input;
    logic [TSD_OPT_OUT_N-1:0]    option_output;
  } tsd_opt_s;

  // one nibble to its seven-segment pattern, characters 0 to f
  function automatic tsd_digit_t tsd_hex_font(input logic [3:0] nib);
    tsd_digit_t seg;
    case (nib)
      4'h0:    seg = 8'h3f;
      4'h1:    seg = 8'h06;
      4'h2:    seg = 8'h5b;
      4'h3:    seg = 8'h4f;
      4'h4:    seg = 8'h66;
      4'h5:    seg = 8'h6d;
      4'h6:    seg = 8'h7d;
      4'h7:    seg = 8'h07;
      4'h8:    seg = 8'h7f;
      4'h9:    seg = 8'h6f;
      4'ha:    seg = 8'h77;
      4'hb:    seg = 8'h7c;
      4'hc:    seg = 8'h39;
      4'hd:    seg = 8'h5e;
      4'he:    seg = 8'h79;
      default: seg = 8'h71;
    endcase
    return seg;
  endfunction : tsd_hex_font

endpackage : tsd_pkg

// ==== design/tsd_hex_digits.sv ====
// status word to four hexadecimal seven-segment digits
`timescale 1ns/1ps
module tsd_hex_digits (
  input  wire tsd_pkg::tsd_word_t word,
  output logic [31:0]             segs
);
  import tsd_pkg::*;

  // digit 3 (leftmost) carries bits 15..12, digit 0 carries bits 3..0
  always_comb begin
    for (int i = 0; i < TSD_DIGITS; i++) begin
      segs[i*8 +: 8] = tsd_hex_font(word[i*4 +: 4]); // R6 R17
    end
  end

endmodule : tsd_hex_digits

// ==== design/tsd_status_display.sv ====
// terminal status display: sampling, status words, segment view and apb registers
`timescale 1ns/1ps

// How it works
// (R1) segment view: rightmost digit a..g follow forward, reverse, general inputs one..five
// (R2) segment view: third digit a,b follow transistor outputs one and two
// (R3) segment view: leftmost digit a follows the relay contact
// (R4) segment view: all terminals off shows a dash on every digit
// (R5) hex view: 16-bit word, unassigned bits forced to zero
// (R6) hex view: leftmost digit bits 15..12, rightmost bits 3..0
// (R7) input word: forward run bit 0, reverse run bit 1, one when closed
// (R8) input word: general inputs one..five at bits 2..6
// (R9) output word: transistor outputs one and two at bits 0 and 1
// (R10) output word: relay contact at bit 8, one when closed
// (R11) comm view shows the received command word in the same formats
// (R12) comm view puts forward, reverse, alarm reset commands at bits 13..15
// (R13) comm view shows signals in normal, non-inverted logic
// (R14) option words: inputs at bits 0..11, select bit 12, outputs bits 0..7
// (R15) option segment view spreads inputs, select and outputs over three digits
// (R16) software selects segment view or hexadecimal view
// (R17) each nibble rendered as one hex character 0..f
// (R18) inputs sampled every clock, display refreshed from samples every cycle
module tsd_status_display (
  input  wire                    core_clk,
  input  wire                    rstn,
  // apb slave
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [7:0]              paddr,
  input  wire [31:0]             pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // terminals and commands
  input  wire tsd_pkg::tsd_term_s terminals,
  input  wire tsd_pkg::tsd_comm_s comm_commands,
  input  wire tsd_pkg::tsd_opt_s  option_board,
  // led monitor, digit 3 leftmost in bits 31..24
  output logic [31:0]            led_segments,
  output tsd_pkg::tsd_word_t     shown_word
);
  import tsd_pkg::*;

  // registered samples of the terminal, command and option board inputs
  tsd_term_s                     term_q;
  tsd_comm_s                     comm_q;
  tsd_opt_s                      opt_q;

  // control
  logic [31:0]                   ctrl;
  logic                          hex_mode;
  logic [1:0]                    view_src;
  logic                          word_sel;

  // assembled words
  tsd_word_t                     term_in_word;
  tsd_word_t                     term_out_word;
  tsd_word_t                     comm_in_word;
  tsd_word_t                     opt_in_word;
  tsd_word_t                     opt_out_word;
  tsd_word_t                     sel_in_word;
  tsd_word_t                     sel_out_word;
  tsd_word_t                     next_shown_word;

  // segment images
  logic [31:0]                   hex_segs;
  logic [31:0]                   term_segs;
  logic [31:0]                   comm_segs;
  logic [31:0]                   opt_segs;
  logic [31:0]                   next_led_segments;

  // apb
  logic                          apb_setup;
  logic                          apb_write;
  logic                          addr_hit;
  logic [31:0]                   next_prdata;
  logic                          rd_err;

  // ---------------------------------------------------------------
  // input sampling
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      term_q <= '0;
      comm_q <= '0;
      opt_q  <= '0;
    end else begin
      term_q <= terminals; // R18
      comm_q <= comm_commands; // R18
      opt_q  <= option_board; // R18
    end
  end

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  assign hex_mode = ctrl[TSD_CTRL_HEX_BIT];
  assign view_src = ctrl[TSD_CTRL_SRC_LSB +: 2];
  assign word_sel = ctrl[TSD_CTRL_WSEL_BIT];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl <= TSD_CTRL_RESET;
    end else if (apb_write && paddr == TSD_OFF_CTRL) begin
      ctrl <= pwdata & TSD_CTRL_MASK; // R16
    end
  end

  // ---------------------------------------------------------------
  // status words
  // ---------------------------------------------------------------
  always_comb begin
    term_in_word                                 = TSD_WORD_ZERO; // R5
    term_in_word[TSD_BIT_FWD]                    = term_q.forward_run_input; // R7
    term_in_word[TSD_BIT_REV]                    = term_q.reverse_run_input; // R7
    term_in_word[TSD_BIT_GEN_LSB +: TSD_GEN_N]   = term_q.general_input; // R8
  end

  always_comb begin
    term_out_word                                = TSD_WORD_ZERO; // R5
    term_out_word[TSD_BIT_TR_LSB +: TSD_TR_N]    = term_q.transistor_output; // R9
    term_out_word[TSD_BIT_RELAY]                 = term_q.relay_contact_output; // R10
  end

  // command word taken as received, no inversion
  always_comb begin
    comm_in_word                 = comm_q.comm_input_command_word; // R11 R13
    comm_in_word[TSD_BIT_CFWD]   = comm_q.comm_forward_command; // R12
    comm_in_word[TSD_BIT_CREV]   = comm_q.comm_reverse_command; // R12
    comm_in_word[TSD_BIT_CRST]   = comm_q.comm_alarm_reset_command; // R12
  end

  always_comb begin
    opt_in_word                                  = TSD_WORD_ZERO; // R5
    opt_in_word[TSD_OPT_IN_N-1:0]                = opt_q.option_input; // R14
    opt_in_word[TSD_BIT_OPT_SEL]                 = opt_q.option_select_input; // R14
  end

  always_comb begin
    opt_out_word                                 = TSD_WORD_ZERO; // R5
    opt_out_word[TSD_BIT_OPT_OLSB +: TSD_OPT_OUT_N] = opt_q.option_output; // R14
  end

  // source selection; unused code falls back to the terminals
  always_comb begin
    case (view_src)
      TSD_SRC_COMM: begin
        sel_in_word  = comm_in_word; // R11
        sel_out_word = term_out_word;
      end
      TSD_SRC_OPT: begin
        sel_in_word  = opt_in_word;
        sel_out_word = opt_out_word;
      end
      default: begin
        sel_in_word  = term_in_word;
        sel_out_word = term_out_word;
      end
    endcase
  end

  assign next_shown_word = word_sel ? sel_out_word : sel_in_word;

  // ---------------------------------------------------------------
  // hexadecimal rendering
  // ---------------------------------------------------------------
  tsd_hex_digits u_hex_digits (
    .word (next_shown_word),
    .segs (hex_segs)
  );

  // ---------------------------------------------------------------
  // segment view for the control terminals
  // ---------------------------------------------------------------
  always_comb begin
    term_segs = '0;
    term_segs[TSD_SEG_A +: 7] = term_in_word[TSD_BIT_FWD +: 7]; // R1
    term_segs[16 + TSD_SEG_A] = term_q.transistor_output[0]; // R2
    term_segs[16 + TSD_SEG_B] = term_q.transistor_output[1]; // R2
    term_segs[24 + TSD_SEG_A] = term_q.relay_contact_output; // R3
    if (term_in_word == TSD_WORD_ZERO && term_out_word == TSD_WORD_ZERO) begin
      term_segs = {TSD_DIGITS{TSD_SEG_DASH}}; // R4
    end
  end

  // comm view: same layout, link commands on the second digit
  always_comb begin
    comm_segs = '0;
    comm_segs[TSD_SEG_A +: 7] = comm_in_word[TSD_BIT_FWD +: 7]; // R11
    comm_segs[8 + TSD_SEG_F]  = comm_in_word[TSD_BIT_CFWD]; // R12
    comm_segs[8 + TSD_SEG_G]  = comm_in_word[TSD_BIT_CREV]; // R12
    comm_segs[8 + TSD_SEG_DP] = comm_in_word[TSD_BIT_CRST]; // R12
    comm_segs[16 + TSD_SEG_A] = term_q.transistor_output[0]; // R2
    comm_segs[16 + TSD_SEG_B] = term_q.transistor_output[1]; // R2
    comm_segs[24 + TSD_SEG_A] = term_q.relay_contact_output; // R3
    if (comm_in_word == TSD_WORD_ZERO && term_out_word == TSD_WORD_ZERO) begin
      comm_segs = {TSD_DIGITS{TSD_SEG_DASH}}; // R4
    end
  end

  // option board view, leftmost digit dark
  always_comb begin
    opt_segs           = '0;
    opt_segs[7:0]      = opt_q.option_input[7:0]; // R15
    opt_segs[11:8]     = opt_q.option_input[11:8]; // R15
    opt_segs[12]       = opt_q.option_select_input; // R15
    opt_segs[23:16]    = opt_q.option_output; // R15
  end

  // ---------------------------------------------------------------
  // display refresh
  // ---------------------------------------------------------------
  always_comb begin
    if (hex_mode) begin
      next_led_segments = hex_segs; // R6 R16
    end else begin
      case (view_src)
        TSD_SRC_COMM: next_led_segments = comm_segs;
        TSD_SRC_OPT:  next_led_segments = opt_segs;
        default:      next_led_segments = term_segs;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      led_segments <= {TSD_DIGITS{TSD_SEG_BLANK}};
      shown_word   <= TSD_WORD_ZERO;
    end else begin
      led_segments <= next_led_segments; // R18
      shown_word   <= next_shown_word; // R18
    end
  end

  // ---------------------------------------------------------------
  // apb slave: read data latched in setup, answered in first access cycle
  // ---------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && addr_hit;
  assign pready    = psel && penable;

  always_comb begin
    addr_hit    = (paddr[1:0] == TSD_ALIGN_OK);
    next_prdata = '0;
    case (paddr)
      TSD_OFF_CTRL:     next_prdata = ctrl;
      TSD_OFF_IN_WORD:  next_prdata = {16'h0000, sel_in_word};
      TSD_OFF_OUT_WORD: next_prdata = {16'h0000, sel_out_word};
      TSD_OFF_SEG:      next_prdata = led_segments;
      TSD_OFF_TERM_RAW: next_prdata = {16'h0000, term_in_word[7:0], term_out_word[8],
                                       5'h00, term_out_word[1:0]};
      TSD_OFF_OPT_RAW:  next_prdata = {11'h000, opt_q};
      default:          addr_hit    = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata <= '0;
      rd_err <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      rd_err <= !addr_hit;
    end
  end

  assign pslverr = pready && rd_err;

endmodule : tsd_status_display

// ==== sim/tsd_contacts.sv ====
// switch contacts, loads and command source wired to the block's inputs
`timescale 1ns/1ps
module tsd_contacts (
  input  wire logic [9:0]   term_closed,
  input  wire logic [18:0]  comm_sent,
  input  wire logic [20:0]  opt_closed,
  output tsd_pkg::tsd_term_s terminals,
  output tsd_pkg::tsd_comm_s comm_commands,
  output tsd_pkg::tsd_opt_s  option_board
);
  import tsd_pkg::*;
  // a closed contact reads one, commands arrive in normal logic
  assign terminals     = tsd_term_s'(term_closed);
  assign comm_commands = tsd_comm_s'(comm_sent);
  assign option_board  = tsd_opt_s'(opt_closed);
endmodule : tsd_contacts

// ==== sim/tsd_status_display_asserts.sv ====
// concurrent checks on the terminal status display ports
`timescale 1ns/1ps
module tsd_checker (
  input wire                     core_clk,
  input wire                     rstn,
  input wire                     psel,
  input wire                     penable,
  input wire                     pwrite,
  input wire [7:0]               paddr,
  input wire [31:0]              pwdata,
  input wire tsd_pkg::tsd_term_s terminals,
  input wire tsd_pkg::tsd_comm_s comm_commands,
  input wire tsd_pkg::tsd_opt_s  option_board,
  input wire [31:0]              led_segments,
  input wire tsd_pkg::tsd_word_t shown_word
);
  import tsd_pkg::*;
  localparam logic [7:0] FONT [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                                       8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  logic [3:0]  ctl, cd;
  logic [1:0]  cnt;
  logic [79:0] v1, v2;
  logic [15:0] pi, po, pc, poi, poo;
  logic        ok, st, sc, so;
  assign {pi, po, pc, poi, poo} = v2;
  assign ok = cnt == 2'h3;
  assign st = cd[2:1] == 2'h0 || cd[2:1] == 2'h3;
  assign sc = cd[2:1] == 2'h1;
  assign so = cd[2:1] == 2'h2;
  // expected words two edges back, matching sample plus output flop
  always_ff @(posedge core_clk) begin
    v1 <= {9'h0, terminals[6:0], 7'h0, terminals[9], 6'h0, terminals[8:7],
           comm_commands[18:16], comm_commands[12:0], 3'h0, option_board[20:8],
           8'h0, option_board[7:0]};
    v2 <= v1;
    cd <= ctl;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctl <= 4'h0;
      cnt <= 2'h0;
    end else begin
      if (psel && penable && pwrite && paddr == TSD_OFF_CTRL) begin
        ctl <= pwdata[3:0];
      end
      if (!ok) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_term_in_word: assert property (ok && st && !cd[3] |-> shown_word == pi)
    else $error("terminal input word wrong");
  a_term_out_word: assert property (ok && st && cd[3] |-> shown_word == po)
    else $error("terminal output word wrong");
  a_comm_in_word: assert property (ok && sc && !cd[3] |-> shown_word == pc)
    else $error("command word wrong");
  a_opt_word: assert property (ok && so |-> shown_word == (cd[3] ? poo : poi))
    else $error("option word wrong");
  a_hex_render: assert property (ok && cd[0] |-> led_segments == {FONT[shown_word[15:12]],
    FONT[shown_word[11:8]], FONT[shown_word[7:4]], FONT[shown_word[3:0]]})
    else $error("hex digits wrong");
  a_seg_term: assert property (ok && st && !cd[0] && (pi | po) != 16'h0
    |-> led_segments == {7'h0, po[8], 6'h0, po[1:0], 9'h0, pi[6:0]})
    else $error("terminal segments wrong");
  a_idle_dashes: assert property (ok && st && !cd[0] && (pi | po) == 16'h0
    |-> led_segments == 32'h40404040)
    else $error("idle dashes missing");
  a_opt_seg: assert property (ok && so && !cd[0]
    |-> led_segments == {8'h0, poo[7:0], 3'h0, poi[12:0]})
    else $error("option segments wrong");
  c_hex_view: cover property (ok && cd[0] && shown_word != 16'h0);
  c_comm_view: cover property (ok && sc && pc[15:13] != 3'h0);
  c_opt_view: cover property (ok && so && !cd[0]);
endmodule : tsd_checker

bind tsd_status_display tsd_checker u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .terminals(terminals), .comm_commands(comm_commands),
  .option_board(option_board), .led_segments(led_segments), .shown_word(shown_word));

// ==== sim/tsd_status_display_tb.sv ====
// self-checking bench for the terminal status display
`timescale 1ns/1ps
module tsd_status_display_tb;
  import tsd_pkg::*;
  localparam logic [7:0] FONT [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
                                       8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, led_segments, rd;
  logic [9:0]  term_closed;
  logic [18:0] comm_sent;
  logic [20:0] opt_closed;
  tsd_term_s   terminals;
  tsd_comm_s   comm_commands;
  tsd_opt_s    option_board;
  tsd_word_t   shown_word;
  int          fails, total_checks, cycles;

  tsd_status_display uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .terminals(terminals), .comm_commands(comm_commands),
    .option_board(option_board), .led_segments(led_segments), .shown_word(shown_word));
  tsd_contacts u_far (.term_closed(term_closed), .comm_sent(comm_sent),
    .opt_closed(opt_closed), .terminals(terminals), .comm_commands(comm_commands),
    .option_board(option_board));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // apply contact states, then let sample and output flops settle
  task automatic drive(input logic [9:0] t, input logic [18:0] c, input logic [20:0] o);
    @(posedge core_clk);
    term_closed <= t;
    comm_sent   <= c;
    opt_closed  <= o;
    repeat (3) @(posedge core_clk);
  endtask : drive

  function automatic logic [31:0] hx(input logic [15:0] w);
    return {FONT[w[15:12]], FONT[w[11:8]], FONT[w[7:4]], FONT[w[3:0]]};
  endfunction : hx

  task automatic t_regs;
    apb(1'b0, TSD_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, TSD_OFF_CTRL, 32'hffffffff);
    apb(1'b0, TSD_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000000f, "ctrl readback");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'h02, 32'h0);
    chk({31'h0, er}, 32'h1, "misaligned err");
  endtask : t_regs

  task automatic t_seg_term;
    logic [9:0] t;
    apb(1'b1, TSD_OFF_CTRL, 32'h0);
    drive(10'h0, 19'h0, 21'h0);
    chk(led_segments, 32'h40404040, "dashes");
    for (int i = 0; i < 10; i++) begin
      t = 10'h1 << i;
      drive(t, 19'h0, 21'h0);
      chk(led_segments, {7'h0, t[9], 6'h0, t[8:7], 9'h0, t[6:0]}, "seg term");
      chk({16'h0, shown_word}, {25'h0, t[6:0]}, "in word");
    end
  endtask : t_seg_term

  task automatic t_hex_term;
    apb(1'b1, TSD_OFF_CTRL, 32'h1);
    drive(10'h005, 19'h0, 21'h0);
    chk(led_segments, hx(16'h0005), "hex fwd x1");
    drive(10'h3ff, 19'h0, 21'h0);
    chk({16'h0, shown_word}, 32'h007f, "hex all in");
    apb(1'b1, TSD_OFF_CTRL, 32'h9);
    drive(10'h280, 19'h0, 21'h0);
    chk(led_segments, hx(16'h0101), "hex y1 relay");
    apb(1'b0, TSD_OFF_OUT_WORD, 32'h0);
    chk(rd, 32'h00000101, "out word reg");
    apb(1'b0, TSD_OFF_TERM_RAW, 32'h0);
    chk(rd, 32'h00000081, "term raw reg");
    apb(1'b0, TSD_OFF_SEG, 32'h0);
    chk(rd, hx(16'h0101), "seg reg");
  endtask : t_hex_term

  task automatic t_comm;
    logic [15:0] w;
    apb(1'b1, TSD_OFF_CTRL, 32'h3);
    for (int i = 0; i < 16; i++) begin
      w = 16'h1111 * i[3:0];
      drive(10'h0, {i[2:0], w}, 21'h0);
      chk({16'h0, shown_word}, {16'h0, i[2:0], w[12:0]}, "comm word");
      chk(led_segments, hx({i[2:0], w[12:0]}), "hex font");
    end
    apb(1'b1, TSD_OFF_CTRL, 32'h2);
    drive(10'h0, 19'h7007f, 21'h0);
    chk(led_segments, 32'h0000e07f, "comm seg");
  endtask : t_comm

  task automatic t_opt;
    apb(1'b1, TSD_OFF_CTRL, 32'h4);
    drive(10'h0, 19'h0, {1'b1, 12'ha5c, 8'h3c});
    chk(led_segments, 32'h003c1a5c, "opt seg");
    chk({16'h0, shown_word}, 32'h1a5c, "opt in word");
    apb(1'b0, TSD_OFF_IN_WORD, 32'h0);
    chk(rd, 32'h00001a5c, "in word reg");
    apb(1'b0, TSD_OFF_OPT_RAW, 32'h0);
    chk(rd, 32'h001a5c3c, "opt raw reg");
    apb(1'b1, TSD_OFF_CTRL, 32'hd);
    drive(10'h0, 19'h0, {1'b0, 12'hfff, 8'hc3});
    chk(led_segments, hx(16'h00c3), "opt out hex");
  endtask : t_opt

  // reset in mid-run: display blanks, control clears, sampling resumes
  task automatic t_reset;
    apb(1'b1, TSD_OFF_CTRL, 32'h9);
    drive(10'h3ff, 19'h0, 21'h0);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(led_segments, 32'h0, "reset blank");
    chk({16'h0, shown_word}, 32'h0, "reset word");
    @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, TSD_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl after reset");
    drive(10'h3ff, 19'h0, 21'h0);
    chk(led_segments, 32'h0103007f, "seg after reset");
  endtask : t_reset

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    term_closed = 10'h0;
    comm_sent = 19'h0;
    opt_closed = 21'h0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_seg_term();
    t_hex_term();
    t_comm();
    t_opt();
    t_reset();
    tally_and_finish();
  end
endmodule : tsd_status_display_tb
